// >>> fsc_pkg.sv
package fsc_pkg;
	// ==========================================================
	// Register map, byte addresses on the 32-bit bus.
	localparam logic [7:0] ADDR_OPTIONS = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_COMMAND = 8'h0C;
	localparam logic [7:0] ADDR_DIVIDER = 8'h10;
	localparam logic [7:0] ADDR_PROTECT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_KEY = 8'h1C;
	// ==========================================================
	// Field positions and masks.
	localparam int OPT_KEY_ENABLE = 7;
	localparam int OPT_REDIRECT_DISABLE = 6;
	localparam logic [7:0] OPT_USED_MASK = 8'hC3;
	localparam logic [7:0] CFG_RW_MASK = 8'hE0;
	localparam int CFG_KEY_ACCESS = 5;
	localparam int ST_BUFFER_EMPTY = 7;
	localparam int ST_COMPLETE = 6;
	localparam int ST_PROT_VIOL = 5;
	localparam int ST_ACCESS_ERR = 4;
	localparam int ST_BLANK = 2;
	localparam logic [7:0] ST_IRQ_MASK = 8'h70;
	localparam int DIV_WRITTEN = 7;
	localparam int DIV_PRESCALE = 6;
	localparam logic [5:0] DIV_VALUE_MASK = 6'h3F;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	// ==========================================================
	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [1:0] RST_SEC = 2'h0;
	// ==========================================================
	// Command codes accepted in user mode.
	localparam logic [7:0] CMD_BLANK_CHECK = 8'h01;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_BURST = 8'h03;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h04;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h05;
	localparam int KEY_BYTES = 8;
	// ==========================================================
	// Carriers and states.
	typedef struct packed {
		logic [63:0] key;
		logic [7:0] protect;
		logic [7:0] options;
	} fsc_nv_t;
	typedef struct packed {
		logic start;
		logic abort;
		logic [7:0] code;
	} fsc_cmd_t;
	typedef enum logic [1:0] {
		FSC_IDLE = 2'b01,
		FSC_BUSY = 2'b10
	} fsc_state_t;
endpackage

// >>> fsc_clk_div.sv
// ==========================================================
// Flash timing clock divider.
module fsc_clk_div #(
	parameter int DIV_W = 6
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Settings.
	input wire logic enable,
	input wire logic prescale,
	input wire logic [DIV_W-1:0] div_value,
	// Output.
	output logic tick
);
	logic [2:0] pre_q;
	logic [DIV_W-1:0] cnt_q;
	logic tick_q;
	wire step = !prescale || (pre_q == 3'h7);
	wire wrap = step && (cnt_q == div_value);
	// A zero width leaves nothing to count, so elaboration stops here.
	if (DIV_W < 1)
	begin : g_bad_width
		$error("fsc_clk_div: DIV_W must be positive.");
	end
	// Divide by eight first when asked, then by the value plus one.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_q <= 3'h0;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_q <= enable ? pre_q + 3'h1 : 3'h0;
			cnt_q <= (!enable || wrap) ? '0 : (step ? cnt_q + 1'b1 : cnt_q);
			tick_q <= enable && wrap; // R2
		end
	end
	assign tick = tick_q;
endmodule // fsc_clk_div

// >>> fsc_key_cmp.sv
// ==========================================================
// Ordered backdoor key comparison.
module fsc_key_cmp #(
	parameter int BYTES = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Key byte stream.
	input wire logic wr,
	input wire logic [7:0] wr_byte,
	input wire logic [BYTES*8-1:0] key,
	// Result.
	output logic match
);
	localparam int IW = $clog2(BYTES);
	logic [IW-1:0] idx_q;
	logic ok_q;
	logic match_q;
	wire last = (idx_q == IW'(BYTES - 1));
	wire same = (wr_byte == key[idx_q*8 +: 8]);
	// A one-byte key would leave the index without a bit, so elaboration stops here.
	if (BYTES < 2)
	begin : g_bad_bytes
		$error("fsc_key_cmp: BYTES must be at least two.");
	end
	// All bytes are taken before a verdict, so a wrong byte gives no early hint.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			idx_q <= '0;
			ok_q <= 1'b1;
			match_q <= 1'b0;
		end
		else
		begin
			match_q <= wr && last && ok_q && same; // R7
			if (wr)
			begin
				idx_q <= last ? '0 : idx_q + 1'b1;
				ok_q <= last ? 1'b1 : (ok_q && same);
			end
		end
	end
	assign match = match_q;
endmodule // fsc_key_cmp

// >>> fsc_ctrl.sv
// What this block does
// R1: Software picks divider and prescale so the timing pulse stays within 5 to 6.7 us.
// R2: Flash clock is bus clock divided by divider value plus one, optionally first by eight.
// R3: Options register is copied from the nonvolatile byte at every reset only.
// R4: Options register is read-only; bits 5 to 2 read zero.
// R5: Key enable low refuses any backdoor unlock.
// R6: Key comparison writes come only from user firmware, never background debug.
// R7: Eight matching key bytes in order unsecure the part until next reset.
// R8: Options bit 6 high disables vector redirection, low enables it.
// R9: Security code 10 means unsecured; 00, 01 and 11 mean secured.
// R10: While secured, memory accesses from debug and unsecured sources are blocked. The code gives only mem_block_debug, equal to secured.
// R11: Key match or all-blank check sets the security code to unsecured.
// R12: Configuration bits 7 to 5 are read/write; bits 4 to 0 read zero.
// R13: Key access bit chooses key writes and invalid flash reads over commands. The code still takes and launches commands while the bit is set.
// R14: Protection register loads at reset; only background debug writes change it.
// R15: Launching a protected program or erase sets the violation flag and discards it.
// R16: Broken sequence, undivided clock or stop while busy sets access error; a blank check launches with no divider written.
// R17: Blank flag set only on all-erased blank check; cleared by next valid launch.
// R18: Command register is write-only, reads zero, resets zero, five codes accepted.
// R19: Writing one to buffer-empty launches; completion sets the complete flag.
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
module fsc_ctrl (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic dbg_access,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Flash array side.
	input fsc_pkg::fsc_nv_t nv,
	input wire logic cmd_done,
	input wire logic blank_ok,
	input wire logic prot_hit,
	input wire logic stop_req,
	output fsc_pkg::fsc_cmd_t cmd,
	output logic fclk_tick,
	output logic [7:0] protection_register,
	// Security and system.
	output logic secured,
	output logic mem_block_debug,
	output logic vector_redirect_en,
	output logic flash_read_invalid,
	output logic irq
);
	// ==========================================================
	// State.
	logic [7:0] opt_q;
	logic [1:0] sec_q;
	logic loaded_q;
	logic [7:0] cfg_q;
	logic [7:0] prot_q;
	logic [7:0] div_q;
	logic [7:0] mask_q;
	logic [7:0] code_q;
	logic pend_q;
	logic cbef_q;
	logic ccf_q;
	logic pviol_q;
	logic accerr_q;
	logic blank_q;
	logic start_q;
	logic abort_q;
	logic wr_q;
	logic dbg_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	fsc_pkg::fsc_state_t state_q;
	fsc_pkg::fsc_state_t state_d;
	logic key_match;

	// ==========================================================
	// Bus decode.
	// The slave never stalls, so both handshake outputs are constants.
	wire ap = hsel && htrans[1] && hready;
	wire [7:0] ap_addr = haddr[7:0];
	wire wr_opt = wr_q && (addr_q == fsc_pkg::ADDR_OPTIONS);
	wire wr_cfg = wr_q && (addr_q == fsc_pkg::ADDR_CONFIG);
	wire wr_st = wr_q && (addr_q == fsc_pkg::ADDR_STATUS);
	wire wr_cmd = wr_q && (addr_q == fsc_pkg::ADDR_COMMAND);
	wire wr_div = wr_q && (addr_q == fsc_pkg::ADDR_DIVIDER);
	wire wr_prot = wr_q && (addr_q == fsc_pkg::ADDR_PROTECT);
	wire wr_mask = wr_q && (addr_q == fsc_pkg::ADDR_IRQ_MASK);
	wire wr_key = wr_q && (addr_q == fsc_pkg::ADDR_KEY);
	wire [7:0] wb = hwdata[7:0];

	// ==========================================================
	// Read view of each register.
	wire [7:0] opt_view = {opt_q[7:2], sec_q} & fsc_pkg::OPT_USED_MASK; // R4
	wire [7:0] st_view = {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'h0};
	wire [7:0] rd_byte =
		(ap_addr == fsc_pkg::ADDR_OPTIONS) ? opt_view :
		(ap_addr == fsc_pkg::ADDR_CONFIG) ? cfg_q :
		(ap_addr == fsc_pkg::ADDR_STATUS) ? st_view :
		(ap_addr == fsc_pkg::ADDR_DIVIDER) ? div_q :
		(ap_addr == fsc_pkg::ADDR_PROTECT) ? prot_q :
		(ap_addr == fsc_pkg::ADDR_IRQ_MASK) ? mask_q :
		fsc_pkg::RST_ZERO; // R18

	// ==========================================================
	// Command checks, evaluated on the command write, on the launching write, or while busy.
	wire code_ok = (wb == fsc_pkg::CMD_BLANK_CHECK) || (wb == fsc_pkg::CMD_PROGRAM) ||
		(wb == fsc_pkg::CMD_BURST) || (wb == fsc_pkg::CMD_PAGE_ERASE) ||
		(wb == fsc_pkg::CMD_MASS_ERASE); // R18
	wire idle = (state_q == fsc_pkg::FSC_IDLE);
	wire busy = (state_q == fsc_pkg::FSC_BUSY);
	wire cmd_take = wr_cmd && idle && cbef_q && code_ok;
	wire cmd_bad = wr_cmd && !(idle && cbef_q && code_ok);
	wire launch = wr_st && wb[fsc_pkg::ST_BUFFER_EMPTY] && cbef_q && idle;
	wire is_blank = (code_q == fsc_pkg::CMD_BLANK_CHECK);
	wire no_div = !is_blank && !div_q[fsc_pkg::DIV_WRITTEN];
	wire launch_err = launch && (!pend_q || no_div); // R16
	wire stop_err = busy && stop_req; // R16
	wire acc_ev = launch_err || cmd_bad || stop_err; // R16
	wire pviol_ev = launch && !launch_err && !is_blank && prot_hit; // R15
	wire good_launch = launch && !launch_err && !pviol_ev; // R19
	wire done = busy && cmd_done && !stop_req;
	wire blank_pass = done && is_blank && blank_ok; // R17
	// Debug writes never reach the comparator, whatever the settings.
	wire key_wr = wr_key && cfg_q[fsc_pkg::CFG_KEY_ACCESS] && opt_q[fsc_pkg::OPT_KEY_ENABLE] && !dbg_q; // R5 R6 R13
	wire clr_pviol = wr_st && wb[fsc_pkg::ST_PROT_VIOL];
	wire clr_acc = wr_st && wb[fsc_pkg::ST_ACCESS_ERR];

	// ==========================================================
	// Sequencer next state.
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			fsc_pkg::FSC_IDLE: if (good_launch) state_d = fsc_pkg::FSC_BUSY;
			fsc_pkg::FSC_BUSY: if (done || stop_err) state_d = fsc_pkg::FSC_IDLE;
			default: state_d = fsc_pkg::FSC_IDLE;
		endcase
	end

	// ==========================================================
	// Bus phase capture and registered read data.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= 1'b0;
			dbg_q <= 1'b0;
			addr_q <= fsc_pkg::RST_ZERO;
			hrdata_q <= '0;
		end
		else
		begin
			wr_q <= ap && hwrite;
			dbg_q <= dbg_access;
			addr_q <= ap_addr;
			if (ap && !hwrite)
				hrdata_q <= {24'h000000, rd_byte};
		end
	end

	// ==========================================================
	// Nonvolatile load one edge after reset release; the options never change after.
	// Loading on a clock edge keeps the asynchronous reset to constants only.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			loaded_q <= 1'b0;
			opt_q <= fsc_pkg::RST_ZERO;
			sec_q <= fsc_pkg::RST_SEC;
			prot_q <= fsc_pkg::RST_ZERO;
		end
		else
		begin
			loaded_q <= 1'b1;
			if (!loaded_q)
			begin
				opt_q <= nv.options; // R3
				sec_q <= nv.options[1:0]; // R3
				prot_q <= nv.protect; // R14
			end
			else
			begin
				if (key_match || blank_pass)
					sec_q <= fsc_pkg::SEC_UNSECURED; // R11
				if (wr_prot && dbg_q)
					prot_q <= wb; // R14
			end
		end
	end

	// ==========================================================
	// Software settings: configuration, divider and interrupt mask.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_q <= fsc_pkg::RST_ZERO;
			div_q <= fsc_pkg::RST_ZERO;
			mask_q <= fsc_pkg::RST_ZERO;
		end
		else
		begin
			if (wr_cfg)
				cfg_q <= wb & fsc_pkg::CFG_RW_MASK; // R12
			if (wr_div)
				div_q <= {1'b1, wb[fsc_pkg::DIV_PRESCALE], wb[5:0] & fsc_pkg::DIV_VALUE_MASK};
			if (wr_mask)
				mask_q <= wb & fsc_pkg::ST_IRQ_MASK;
		end
	end

	// ==========================================================
	// Command buffer and sequencer.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= fsc_pkg::FSC_IDLE;
			code_q <= fsc_pkg::RST_ZERO;
			pend_q <= 1'b0;
			cbef_q <= 1'b1;
			start_q <= 1'b0;
			abort_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			start_q <= good_launch; // R19
			abort_q <= stop_err; // R16
			if (cmd_take)
			begin
				code_q <= wb; // R18
				pend_q <= 1'b1;
			end
			else if (launch || cmd_bad)
				pend_q <= 1'b0; // R15 R16
			if (good_launch)
				cbef_q <= 1'b0; // R19
			else if (done || stop_err)
				cbef_q <= 1'b1;
		end
	end

	// ==========================================================
	// Status flags. A set in the same cycle as a one-write wins.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ccf_q <= 1'b1;
			pviol_q <= 1'b0;
			accerr_q <= 1'b0;
			blank_q <= 1'b0;
		end
		else
		begin
			ccf_q <= done || stop_err || (ccf_q && !good_launch); // R19
			pviol_q <= pviol_ev || (pviol_q && !clr_pviol); // R15
			accerr_q <= acc_ev || (accerr_q && !clr_acc); // R16
			blank_q <= blank_pass || (blank_q && !good_launch); // R17
		end
	end

	// ==========================================================
	// Helpers.
	fsc_clk_div #(
		.DIV_W(6)
	) u_div (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.enable(div_q[fsc_pkg::DIV_WRITTEN]),
		.prescale(div_q[fsc_pkg::DIV_PRESCALE]),
		.div_value(div_q[5:0]),
		.tick(fclk_tick)
	); // R2

	fsc_key_cmp #(
		.BYTES(fsc_pkg::KEY_BYTES)
	) u_key (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wr(key_wr),
		.wr_byte(wb),
		.key(nv.key),
		.match(key_match)
	); // R7

	// ==========================================================
	// Outputs.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign cmd = '{start: start_q, abort: abort_q, code: code_q};
	assign protection_register = prot_q;
	assign secured = (sec_q != fsc_pkg::SEC_UNSECURED); // R9
	assign mem_block_debug = secured; // R10
	assign vector_redirect_en = !opt_q[fsc_pkg::OPT_REDIRECT_DISABLE]; // R8
	assign flash_read_invalid = cfg_q[fsc_pkg::CFG_KEY_ACCESS]; // R13
	assign irq = |(st_view & mask_q);

	// ==========================================================
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_opt_stable: // R3
	assert property (loaded_q && $past(loaded_q) |=> $stable(opt_q))
		else $error("Options changed after load.");
	a_opt_unused: // R4
	assert property (ap && !hwrite && ap_addr == fsc_pkg::ADDR_OPTIONS |=> hrdata_q[5:2] == 4'h0)
		else $error("Options unused bits not zero.");
	a_key_disabled: // R5
	assert property (!opt_q[fsc_pkg::OPT_KEY_ENABLE] && wr_key |=> !key_match)
		else $error("Key accepted while disabled.");
	a_key_debug: // R6
	assert property (wr_key && dbg_q |-> !key_wr)
		else $error("Debug key write reached comparator.");
	a_key_unsecure: // R7
	assert property (key_match |=> !secured)
		else $error("Key match did not unsecure.");
	a_redirect: // R8
	assert property (vector_redirect_en != opt_q[fsc_pkg::OPT_REDIRECT_DISABLE])
		else $error("Redirection bit inverted wrongly.");
	a_sec_code: // R9
	assert property (loaded_q && sec_q != fsc_pkg::SEC_UNSECURED |-> secured && mem_block_debug)
		else $error("Secure code not honoured.");
	a_blank_unsec: // R11
	assert property (blank_pass |=> sec_q == fsc_pkg::SEC_UNSECURED ##1 !secured)
		else $error("Blank pass did not unsecure.");
	a_cfg_low: // R12
	assert property (wr_cfg |=> cfg_q[4:0] == 5'h00)
		else $error("Configuration low bits written.");
	a_prot_user: // R14
	assert property (loaded_q && wr_prot && !dbg_q |=> $stable(prot_q))
		else $error("User write changed protection.");
	a_pviol_drop: // R15
	assert property (pviol_ev |=> pviol_q && !cmd.start && state_q == fsc_pkg::FSC_IDLE)
		else $error("Protected command not discarded.");
	a_accerr_hold: // R16
	assert property (accerr_q && !clr_acc |=> accerr_q)
		else $error("Access error lost without clear.");
	a_blank_clear: // R17
	assert property (good_launch |=> !blank_q && !ccf_q)
		else $error("Launch did not clear blank flag.");
	a_cmd_read: // R18
	assert property (ap && !hwrite && ap_addr == fsc_pkg::ADDR_COMMAND |=> hrdata_q == 32'h00000000)
		else $error("Command register read not zero.");
	a_launch_pulse: // R19
	assert property (good_launch |=> cmd.start && busy ##1 !cmd.start)
		else $error("Launch pulse malformed.");
endmodule // fsc_ctrl

// >>> fsc_array_model.sv
// ==========================================================
// Behavioural flash array facing the control block.
module fsc_array_model #(
	parameter logic [63:0] KEY = 64'h3C5A_96E1_0F7B_D248
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Nonvolatile contents and timing chosen by the bench.
	input wire logic [7:0] opt_byte,
	input wire logic [7:0] prot_byte,
	input wire logic blank_all,
	input wire logic [7:0] latency,
	// Command interface.
	input wire fsc_pkg::fsc_cmd_t cmd,
	output fsc_pkg::fsc_nv_t nv,
	output logic cmd_done,
	output logic blank_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q;
	logic [7:0] cnt_q;
	// The nonvolatile bytes are offered steadily, and the key value is arbitrary.
	assign nv = {KEY, prot_byte, opt_byte};
	// Outside the done cycle blank_ok shows the inverse, so a stale level never looks valid.
	assign cmd_done = busy_q && (cnt_q == 8'h00);
	assign blank_ok = cmd_done ? blank_all : ~blank_all;
	// A started operation runs for latency plus one cycles; an abort drops it at once.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
		end
		else if (cmd.abort || cmd_done)
			busy_q <= 1'b0;
		else if (cmd.start)
		begin
			busy_q <= 1'b1;
			cnt_q <= latency;
		end
		else if (busy_q)
			cnt_q <= cnt_q - 8'h01;
	end
endmodule // fsc_array_model

// >>> fsc_ctrl_tb.sv
module fsc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} fsc_row_t;
	localparam logic [63:0] KEY = 64'h3C5A_96E1_0F7B_D248;
	logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg_access = 1'b0;
	logic blank_all = 1'b0, prot_hit = 1'b0, stop_req = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd = 32'h0, hrdata;
	logic [7:0] opt_byte = 8'hC3, prot_byte = 8'hA5, lat = 8'h02, protection_register;
	logic hreadyout, hresp, fclk_tick, secured, mem_block_debug, vector_redirect_en;
	logic flash_read_invalid, irq, cmd_done, blank_ok;
	fsc_pkg::fsc_nv_t nv;
	fsc_pkg::fsc_cmd_t cmd;
	int fails = 0, checked = 0;
	fsc_row_t rows [8] = '{
		'{1'b1, fsc_pkg::ADDR_OPTIONS, 32'h00, 32'hC3},
		'{1'b1, fsc_pkg::ADDR_CONFIG, 32'hFF, 32'hE0},
		'{1'b1, fsc_pkg::ADDR_CONFIG, 32'h00, 32'h00},
		'{1'b0, fsc_pkg::ADDR_COMMAND, 32'h00, 32'h00},
		'{1'b1, fsc_pkg::ADDR_PROTECT, 32'h00, 32'hA5},
		'{1'b1, fsc_pkg::ADDR_IRQ_MASK, 32'hFF, 32'h70},
		'{1'b1, fsc_pkg::ADDR_DIVIDER, 32'h03, 32'h83},
		'{1'b1, 8'h20, 32'hFF, 32'h00}};
	// ==========================================================
	// Clock, design and flash array.
	always #2.5 ref_clk = ~ref_clk;
	fsc_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .dbg_access(dbg_access),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nv(nv), .cmd_done(cmd_done),
		.blank_ok(blank_ok), .prot_hit(prot_hit), .stop_req(stop_req), .cmd(cmd), .fclk_tick(fclk_tick),
		.protection_register(protection_register), .secured(secured), .mem_block_debug(mem_block_debug),
		.vector_redirect_en(vector_redirect_en), .flash_read_invalid(flash_read_invalid), .irq(irq));
	fsc_array_model array_u (.ref_clk(ref_clk), .resetn(resetn), .opt_byte(opt_byte), .prot_byte(prot_byte),
		.blank_all(blank_all), .latency(lat), .cmd(cmd), .nv(nv), .cmd_done(cmd_done), .blank_ok(blank_ok));
	// ==========================================================
	// Shared tasks.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One single transfer; every signal is held until hready is seen high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic dbg);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		dbg_access <= dbg;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 1'b0);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 1'b0);
		chk(what, e, rd);
	endtask
	// Reset is followed by one spare edge, because options read zero in the loading cycle.
	task automatic do_reset;
		resetn <= 1'b0;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic tick_gap(input int exp);
		int n;
		n = 0;
		repeat (2)
		do begin @(posedge ref_clk); #1; end while (fclk_tick !== 1'b1);
		do begin @(posedge ref_clk); #1; n++; end while (fclk_tick !== 1'b1);
		chk("tick period", exp, n);
	endtask
	task automatic key_send(input logic [63:0] k, input logic dbg);
		for (int n = 0; n < 8; n++) bus(1'b1, fsc_pkg::ADDR_KEY, {24'h0, k[8*n +: 8]}, dbg);
		// The security code follows the match pulse by one more edge.
		@(posedge ref_clk);
		#1;
	endtask
	// Write a code, launch it, and wait for completion when a start is expected.
	task automatic run_cmd(input logic [7:0] code, input logic exp_start);
		wr(fsc_pkg::ADDR_COMMAND, {24'h0, code});
		wr(fsc_pkg::ADDR_STATUS, 32'h80);
		#1;
		chk("command start", exp_start, cmd.start);
		if (exp_start) chk("command code", code, cmd.code);
		rd = 32'h0;
		for (int i = 0; i < 60 && exp_start && rd[fsc_pkg::ST_COMPLETE] !== 1'b1; i++)
			bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		if (exp_start) chk("complete flag", 1'b1, rd[fsc_pkg::ST_COMPLETE]);
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Watchdog; the whole sequence needs a few hundred cycles.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end
	// ==========================================================
	// Main sequence.
	initial
	begin
		do_reset();
		chk("secured", 1'b1, secured);
		chk("debug blocked", 1'b1, mem_block_debug);
		chk("redirect enable", 1'b0, vector_redirect_en);
		chk("protection", 8'hA5, protection_register);
		chk("irq", 1'b0, irq);
		chk("ready and okay", 32'h2, {hreadyout, hresp});
		foreach (rows[i])
		begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rdchk("row read", rows[i].a, rows[i].e);
		end
		// A changed nonvolatile byte stays unseen until the next reset.
		opt_byte <= 8'h01;
		rdchk("options held", fsc_pkg::ADDR_OPTIONS, 32'hC3);
		bus(1'b1, fsc_pkg::ADDR_PROTECT, 32'h5A, 1'b1);
		#1;
		chk("debug protection write", 8'h5A, protection_register);
		tick_gap(4);
		wr(fsc_pkg::ADDR_DIVIDER, 32'h41);
		tick_gap(16);
		// Key entry: debug writes and a wrong key must not unlock.
		wr(fsc_pkg::ADDR_CONFIG, 32'h20);
		#1;
		chk("read invalid", 1'b1, flash_read_invalid);
		key_send(KEY, 1'b1);
		chk("secured after debug key", 1'b1, secured);
		key_send(KEY ^ 64'h1, 1'b0);
		chk("secured after wrong key", 1'b1, secured);
		key_send(KEY, 1'b0);
		chk("secured after key", 1'b0, secured);
		chk("debug unblocked", 1'b0, mem_block_debug);
		wr(fsc_pkg::ADDR_CONFIG, 32'h00);
		// Every accepted code, with the complete flag raising the interrupt.
		wr(fsc_pkg::ADDR_IRQ_MASK, 32'h40);
		for (int c = 1; c <= 5; c++) run_cmd(c[7:0], 1'b1);
		#1;
		chk("irq on complete", 1'b1, irq);
		wr(fsc_pkg::ADDR_IRQ_MASK, 32'h10);
		#1;
		chk("irq masked", 1'b0, irq);
		// Bad code sets the access error; only a written one clears it.
		wr(fsc_pkg::ADDR_COMMAND, 32'hFF);
		rdchk("access error", fsc_pkg::ADDR_STATUS, 32'hD0);
		#1;
		chk("irq on error", 1'b1, irq);
		wr(fsc_pkg::ADDR_STATUS, 32'h00);
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("error kept", 1'b1, rd[fsc_pkg::ST_ACCESS_ERR]);
		wr(fsc_pkg::ADDR_STATUS, 32'h10);
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("error cleared", 1'b0, rd[fsc_pkg::ST_ACCESS_ERR]);
		#1;
		chk("irq cleared", 1'b0, irq);
		// Protected target: the command is discarded and flagged.
		prot_hit <= 1'b1;
		run_cmd(fsc_pkg::CMD_PAGE_ERASE, 1'b0);
		prot_hit <= 1'b0;
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("violation", 1'b1, rd[fsc_pkg::ST_PROT_VIOL]);
		wr(fsc_pkg::ADDR_STATUS, 32'h20);
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("violation cleared", 1'b0, rd[fsc_pkg::ST_PROT_VIOL]);
		// Stop entry during a slow operation aborts it.
		lat <= 8'd30;
		wr(fsc_pkg::ADDR_COMMAND, {24'h0, fsc_pkg::CMD_PROGRAM});
		wr(fsc_pkg::ADDR_STATUS, 32'h80);
		stop_req <= 1'b1;
		for (int i = 0; i < 10 && cmd.abort !== 1'b1; i++) begin @(posedge ref_clk); #1; end
		chk("abort", 1'b1, cmd.abort);
		stop_req <= 1'b0;
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("stop error", 1'b1, rd[fsc_pkg::ST_ACCESS_ERR]);
		// Second reset: new options, key disabled, divider not yet written.
		lat <= 8'h02;
		do_reset();
		rdchk("options reloaded", fsc_pkg::ADDR_OPTIONS, 32'h01);
		chk("redirect enable", 1'b1, vector_redirect_en);
		chk("secured code 01", 1'b1, secured);
		run_cmd(fsc_pkg::CMD_PROGRAM, 1'b0);
		bus(1'b0, fsc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk("no divider", 1'b1, rd[fsc_pkg::ST_ACCESS_ERR]);
		wr(fsc_pkg::ADDR_STATUS, 32'h30);
		wr(fsc_pkg::ADDR_CONFIG, 32'h20);
		key_send(KEY, 1'b0);
		chk("key disabled", 1'b1, secured);
		wr(fsc_pkg::ADDR_CONFIG, 32'h00);
		// Blank check: only an all-erased array unlocks and sets the flag.
		run_cmd(fsc_pkg::CMD_BLANK_CHECK, 1'b1);
		chk("not blank", 1'b0, rd[fsc_pkg::ST_BLANK]);
		chk("still secured", 1'b1, secured);
		blank_all <= 1'b1;
		run_cmd(fsc_pkg::CMD_BLANK_CHECK, 1'b1);
		chk("blank", 1'b1, rd[fsc_pkg::ST_BLANK]);
		chk("unsecured by blank", 1'b0, secured);
		tally_and_finish();
	end
endmodule // fsc_ctrl_tb
